// ### src/usb_phy_tune_pkg.sv
package usb_phy_tune_pkg;

  localparam logic [31:0] WIN_BASE        = 32'h4000_7c00;
  localparam logic [31:0] WIN_LAST        = 32'h4000_7fff;
  localparam int          WIN_AW          = 10;
  localparam logic [9:0]  USB2_SET_OFS    = 10'h000;
  localparam logic [9:0]  HSIC_SET_OFS    = 10'h200;
  localparam logic [9:0]  HS_DRV_CTL_OFS  = 10'h000;
  localparam logic [9:0]  REG_TEST_OFS    = 10'h004;
  localparam logic [9:0]  XCVR_SEL_OFS    = 10'h008;
  localparam logic [31:0] ENG_XCVR_OFS    = 32'h0000_2c20;
  localparam logic [31:0] ENG_HSIC_OFS    = 32'h0000_2c24;
  localparam logic [1:0]  WORD_ALIGN      = 2'h0;

  localparam logic [8:0]  HS_DRV_CTL_RST  = 9'h000;
  localparam logic [7:0]  REG_TEST_RST    = 8'h00;
  localparam logic [5:0]  XCVR_CTL_RST    = 6'h03;
  localparam logic [4:0]  HSIC_TRIM_RST   = 5'h03;

  // hs_driver_control fields
  localparam int HDC_SWAP     = 8;
  localparam int HDC_VMASK_LO = 6;
  localparam int HDC_DATA_LO  = 4;
  localparam int HDC_TERM     = 3;
  localparam int HDC_CS_EN    = 2;
  localparam int HDC_CUR_LO   = 0;
  // regulator_test_control fields
  localparam int RTC_GATE     = 7;
  localparam int RTC_REF_LO   = 5;
  localparam int RTC_BIAS     = 4;
  localparam int RTC_HSER_LO  = 2;
  localparam int RTC_LSER_LO  = 0;
  // transceiver_control fields
  localparam int XC_BOOST_LO  = 4;
  localparam int XC_SWAP      = 3;
  localparam int XC_SQ_LO     = 0;
  // transceiver select field in the test enable word
  localparam int XS_SEL_LO    = 2;

  localparam logic [1:0] VMASK_ILLEGAL = 2'h2;
  localparam logic [1:0] REF_TO_TEST   = 2'h3;

  typedef enum logic [1:0] {
    XCVR_HS,
    XCVR_FS,
    XCVR_LS,
    XCVR_LS_FS_EDGE
  } xcvr_mode_t;

endpackage : usb_phy_tune_pkg

// ### src/usb_phy_tune_regs.sv
`timescale 1ns/1ps
module usb_phy_tune_regs
  import usb_phy_tune_pkg::*;
#(
  parameter logic [31:0] ENG_BASE = 32'h4000_0000
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [31:0] bus_addr_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic [31:0] bus_wdata_i,
  output logic      [31:0] bus_rdata_o,
  output logic             bus_ack_o,
  input  wire logic        tx_in_progress_i,
  input  wire logic        link_busy_i,
  output logic             line_swap_o,
  output logic      [1:0]  drive_boost_sel_o,
  output logic      [2:0]  squelch_sel_o,
  output logic      [4:0]  hsic_resistor_trim_o,
  output logic      [1:0]  hs_tx_bit_valid_mask_o,
  output logic      [1:0]  hs_tx_bit_pair_o,
  output logic             hs_termination_on_o,
  output logic             hs_current_source_on_o,
  output logic      [1:0]  hs_output_current_sel_o,
  output logic             detector_enable_o,
  output logic      [1:0]  reference_level_sel_o,
  output logic             reference_to_test_pin_o,
  output logic             receiver_bias_boost_o,
  output logic      [1:0]  hs_edge_rate_sel_o,
  output logic      [1:0]  ls_edge_rate_sel_o,
  output logic      [1:0]  transceiver_select_o
);

  // Two-flop synchronisers for the analog side status
  logic [1:0] tx_sync_r;
  logic [1:0] busy_sync_r;

  logic [8:0] hs_driver_control_r;
  logic [7:0] regulator_test_control_r;
  logic [5:0] transceiver_control_r;
  logic [4:0] hsic_tuning_r;
  logic [1:0] xcvr_sel_r;

  logic       win_hit;
  logic [9:0] win_ofs;
  logic [31:0] eng_ofs;
  logic       hit_hdc;
  logic       hit_rtc;
  logic       hit_xs;
  logic       hit_xc;
  logic       hit_ht;
  logic       sel;
  logic       wr_go;
  logic [31:0] rd_word;

  // Field extraction shared by several write paths
  function automatic logic [1:0] field2(input logic [31:0] w, input int lo);
    field2 = w[lo +: 2];
  endfunction : field2

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sync_r   <= 2'h0;
      busy_sync_r <= 2'h0;
    end else begin
      tx_sync_r   <= {tx_sync_r[0], tx_in_progress_i};
      busy_sync_r <= {busy_sync_r[0], link_busy_i};
    end
  end

  assign win_hit = (bus_addr_i >= WIN_BASE) && (bus_addr_i <= WIN_LAST);
  assign win_ofs = bus_addr_i[WIN_AW-1:0];
  // Engine words sit outside the window, so they get their own offset
  assign eng_ofs = bus_addr_i - ENG_BASE;

  // USB2 set at base; HSIC set starts at 0x200 and holds nothing here
  assign hit_hdc = win_hit && (win_ofs == (USB2_SET_OFS | HS_DRV_CTL_OFS));
  assign hit_rtc = win_hit && (win_ofs == (USB2_SET_OFS | REG_TEST_OFS));
  assign hit_xs  = win_hit && (win_ofs == (USB2_SET_OFS | XCVR_SEL_OFS));
  assign hit_xc  = (bus_addr_i >= ENG_BASE) && (eng_ofs == ENG_XCVR_OFS);
  assign hit_ht  = (bus_addr_i >= ENG_BASE) && (eng_ofs == ENG_HSIC_OFS);
  // Only the window and the two engine words answer; other slaves own the rest
  assign sel     = win_hit || hit_xc || hit_ht;
  // Misaligned writes inside the window are still answered, but never land in a register
  assign wr_go   = bus_wr_i && (bus_addr_i[1:0] == WORD_ALIGN);

  // hs_driver_control write path
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_driver_control_r <= HS_DRV_CTL_RST;
    end else if (wr_go && hit_hdc) begin
      hs_driver_control_r[HDC_SWAP]              <= bus_wdata_i[HDC_SWAP];
      // illegal mask write leaves old mask
      if (field2(bus_wdata_i, HDC_VMASK_LO) != VMASK_ILLEGAL) begin
        hs_driver_control_r[HDC_VMASK_LO +: 2]   <= field2(bus_wdata_i, HDC_VMASK_LO);
      end
      hs_driver_control_r[HDC_DATA_LO +: 2]      <= field2(bus_wdata_i, HDC_DATA_LO);
      hs_driver_control_r[HDC_TERM]              <= bus_wdata_i[HDC_TERM];
      hs_driver_control_r[HDC_CS_EN]             <= bus_wdata_i[HDC_CS_EN];
      hs_driver_control_r[HDC_CUR_LO +: 2]       <= field2(bus_wdata_i, HDC_CUR_LO);
    end
  end

  // regulator_test_control write path
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regulator_test_control_r <= REG_TEST_RST;
    end else if (wr_go && hit_rtc) begin
      regulator_test_control_r <= bus_wdata_i[7:0];
    end
  end

  // Transceiver select; a write while the link is busy is dropped
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xcvr_sel_r <= XCVR_HS;
    end else if (wr_go && hit_xs && !busy_sync_r[1]) begin
      xcvr_sel_r <= field2(bus_wdata_i, XS_SEL_LO);
    end
  end

  // Engine-space transceiver control
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      transceiver_control_r <= XCVR_CTL_RST;
    end else if (wr_go && hit_xc) begin
      transceiver_control_r <= bus_wdata_i[5:0];
    end
  end

  // Engine-space HSIC tuning
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hsic_tuning_r <= HSIC_TRIM_RST;
    end else if (wr_go && hit_ht) begin
      hsic_tuning_r <= bus_wdata_i[4:0];
    end
  end

  // Read mux; narrow registers zero-extended, select value returned at bits 3:2
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_hdc) begin
      rd_word = {23'h000000, hs_driver_control_r};
    end else if (hit_rtc) begin
      rd_word = {24'h000000, regulator_test_control_r};
    end else if (hit_xs) begin
      rd_word = {28'h0000000, xcvr_sel_r, 2'h0};
    end else if (hit_xc) begin
      rd_word = {26'h0000000, transceiver_control_r};
    end else if (hit_ht) begin
      rd_word = {27'h0000000, hsic_tuning_r};
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_ack_o   <= 1'b0;
      bus_rdata_o <= 32'h0000_0000;
    end else begin
      bus_ack_o   <= sel && (bus_wr_i || bus_rd_i);
      bus_rdata_o <= (sel && bus_rd_i) ? rd_word : 32'h0000_0000;
    end
  end

  // Analog control outputs, each registered so the front end sees no glitches.
  // All read zero in reset; register values appear one edge after release.

  // Line swap to the pad mux
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_swap_o <= 1'b0;
    end else begin
      line_swap_o <= transceiver_control_r[XC_SWAP] |
                     hs_driver_control_r[HDC_SWAP];
    end
  end

  // Drive strength boost
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_boost_sel_o <= 2'h0;
    end else begin
      drive_boost_sel_o <= transceiver_control_r[XC_BOOST_LO +: 2];
    end
  end

  // Squelch level
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      squelch_sel_o <= 3'h0;
    end else begin
      squelch_sel_o <= transceiver_control_r[XC_SQ_LO +: 3];
    end
  end

  // HSIC pad trim
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hsic_resistor_trim_o <= 5'h0;
    end else begin
      hsic_resistor_trim_o <= hsic_tuning_r;
    end
  end

  // Transmit valid mask; the write path already refuses 10
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_tx_bit_valid_mask_o <= 2'h0;
    end else begin
      hs_tx_bit_valid_mask_o <= hs_driver_control_r[HDC_VMASK_LO +: 2];
    end
  end

  // Transmit bit pair
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_tx_bit_pair_o <= 2'h0;
    end else begin
      // bit pair, bit 0 sent first
      hs_tx_bit_pair_o <= hs_driver_control_r[HDC_DATA_LO +: 2];
    end
  end

  // High-speed termination
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_termination_on_o <= 1'b0;
    end else begin
      hs_termination_on_o <= hs_driver_control_r[HDC_TERM];
    end
  end

  // Current source; firmware cannot starve the driver in high-speed mode
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_current_source_on_o <= 1'b0;
    end else begin
      hs_current_source_on_o <= hs_driver_control_r[HDC_CS_EN] |
                                (xcvr_sel_r == XCVR_HS);
    end
  end

  // Output current
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_output_current_sel_o <= 2'h0;
    end else begin
      hs_output_current_sel_o <= hs_driver_control_r[HDC_CUR_LO +: 2];
    end
  end

  // Detector enable; gating trades wake-up latency for idle power
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      detector_enable_o <= 1'b0;
    end else begin
      detector_enable_o <= regulator_test_control_r[RTC_GATE] ? tx_sync_r[1] : 1'b1;
    end
  end

  // Reference level code
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reference_level_sel_o <= 2'h0;
    end else begin
      reference_level_sel_o <= regulator_test_control_r[RTC_REF_LO +: 2];
    end
  end

  // Reference to test pin; decoded here, set whenever the reference code is REF_TO_TEST
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reference_to_test_pin_o <= 1'b0;
    end else begin
      reference_to_test_pin_o <= (regulator_test_control_r[RTC_REF_LO +: 2] == REF_TO_TEST);
    end
  end

  // Receiver bias
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      receiver_bias_boost_o <= 1'b0;
    end else begin
      receiver_bias_boost_o <= regulator_test_control_r[RTC_BIAS];
    end
  end

  // High-speed edge rate
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_edge_rate_sel_o <= 2'h0;
    end else begin
      hs_edge_rate_sel_o <= regulator_test_control_r[RTC_HSER_LO +: 2];
    end
  end

  // Low-speed edge rate
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ls_edge_rate_sel_o <= 2'h0;
    end else begin
      ls_edge_rate_sel_o <= regulator_test_control_r[RTC_LSER_LO +: 2];
    end
  end

  // Transceiver mode; only moves when the idle check let the write in
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      transceiver_select_o <= 2'h0;
    end else begin
      transceiver_select_o <= xcvr_sel_r;
    end
  end

endmodule : usb_phy_tune_regs

// ### testbench/usb_phy_tune_properties.sv
`timescale 1ns/1ps
module usb_phy_tune_properties
  import usb_phy_tune_pkg::*;
#(
  parameter logic [31:0] ENG_BASE = 32'h4000_0000
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic        bus_wr_i,
  input wire logic        bus_rd_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic [31:0] bus_rdata_o,
  input wire logic        bus_ack_o,
  input wire logic        line_swap_o,
  input wire logic [2:0]  squelch_sel_o,
  input wire logic [4:0]  hsic_resistor_trim_o,
  input wire logic [1:0]  hs_tx_bit_valid_mask_o,
  input wire logic        hs_current_source_on_o,
  input wire logic        detector_enable_o,
  input wire logic [1:0]  reference_level_sel_o,
  input wire logic        reference_to_test_pin_o,
  input wire logic [1:0]  transceiver_select_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Address owned by this block: window or one of the two engine words
  logic hit;
  assign hit = (bus_addr_i >= WIN_BASE && bus_addr_i <= WIN_LAST)
            || bus_addr_i == ENG_BASE + ENG_XCVR_OFS || bus_addr_i == ENG_BASE + ENG_HSIC_OFS;
  // Steps that open the multi-cycle checks
  sequence s_swap_wr; bus_wr_i && bus_addr_i == WIN_BASE && bus_wdata_i[8]; endsequence
  sequence s_gate_off; bus_wr_i && bus_addr_i == WIN_BASE + 32'h4 && !bus_wdata_i[7]; endsequence
  sequence s_rst_exit; !$past(rst_n_i); endsequence
  // Bus answer and register side effects
  ack_on_hit_a: assert property ((bus_wr_i || bus_rd_i) && hit |=> bus_ack_o)
    else $error("no ack for window access");
  no_ack_out_a: assert property ((bus_wr_i || bus_rd_i) && !hit |=> !bus_ack_o)
    else $error("ack outside window");
  rdata_idle_a: assert property (!bus_ack_o |-> bus_rdata_o == 32'h0)
    else $error("read data outside ack");
  swap_follow_a: assert property (s_swap_wr |=> ##1 line_swap_o)
    else $error("swap not applied");
  vmask_legal_a: assert property (hs_tx_bit_valid_mask_o != VMASK_ILLEGAL)
    else $error("illegal valid mask");
  cs_in_hs_a: assert property ($past(rst_n_i) && transceiver_select_o == XCVR_HS
    |-> hs_current_source_on_o)
    else $error("current source off in high speed");
  ref_pin_a: assert property (
    reference_to_test_pin_o == (reference_level_sel_o == REF_TO_TEST))
    else $error("test pin route mismatch");
  det_free_a: assert property (s_gate_off |=> ##1 detector_enable_o)
    else $error("detectors gated");
  reset_vals_a: assert property (s_rst_exit |=>
    squelch_sel_o == 3'h3 && hsic_resistor_trim_o == 5'h3)
    else $error("reset values wrong");
endmodule : usb_phy_tune_properties
bind usb_phy_tune_regs usb_phy_tune_properties #(.ENG_BASE(ENG_BASE)) u_usb_phy_tune_properties (.*);

// ### testbench/afe_model.sv
`timescale 1ns/1ps
module afe_model (
  input  wire logic tx_req_i,
  input  wire logic busy_req_i,
  output logic      tx_in_progress_o,
  output logic      link_busy_o
);
  // Analog levels move off the bus clock, so the block must resync them
  initial begin
    tx_in_progress_o = 1'b0;
    link_busy_o = 1'b0;
  end
  always @(tx_req_i) tx_in_progress_o <= #3 tx_req_i;
  always @(busy_req_i) link_busy_o <= #3 busy_req_i;
endmodule : afe_model

// ### testbench/usb_phy_tune_regs_bench.sv
`timescale 1ns/1ps
module usb_phy_tune_regs_bench;
  import usb_phy_tune_pkg::*;
  localparam logic [31:0] ENG = 32'h4000_0000;
  logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, bus_wr_i = 1'b0, bus_rd_i = 1'b0;
  logic [31:0] bus_addr_i = 32'h0, bus_wdata_i = 32'h0, bus_rdata_o;
  logic        bus_ack_o, tx_in_progress_i, link_busy_i, tx_req = 1'b0, busy_req = 1'b0;
  logic        line_swap_o, hs_termination_on_o, hs_current_source_on_o, detector_enable_o;
  logic        reference_to_test_pin_o, receiver_bias_boost_o;
  logic [1:0]  drive_boost_sel_o, hs_tx_bit_valid_mask_o, hs_tx_bit_pair_o;
  logic [1:0]  hs_output_current_sel_o;
  logic [1:0]  reference_level_sel_o, hs_edge_rate_sel_o, ls_edge_rate_sel_o, transceiver_select_o;
  logic [2:0]  squelch_sel_o;
  logic [4:0]  hsic_resistor_trim_o;
  int          err_count = 0, tests_run = 0;
  // Design and analog side
  usb_phy_tune_regs #(.ENG_BASE(ENG)) u_usb_phy_tune_regs (.*);
  afe_model u_afe_model (.tx_req_i(tx_req), .busy_req_i(busy_req),
                         .tx_in_progress_o(tx_in_progress_i), .link_busy_o(link_busy_i));
  // 40 MHz bus clock
  always #12.5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One-cycle request pulse; answer judged one cycle later, outputs a cycle after that
  task automatic acc(input logic [31:0] a, input logic w, input logic [31:0] d,
                     input logic ex_ack, input logic [31:0] ex_rd);
    @(posedge sys_clk_i);
    bus_addr_i <= a;
    bus_wdata_i <= d;
    bus_wr_i <= w;
    bus_rd_i <= !w;
    @(posedge sys_clk_i);
    bus_wr_i <= 1'b0;
    bus_rd_i <= 1'b0;
    #1;
    chk(bus_ack_o, ex_ack);
    if (!w) chk(bus_rdata_o, ex_rd);
    @(posedge sys_clk_i);
    #1;
  endtask : acc
  task automatic t_reset;
    acc(WIN_BASE, 1'b0, 32'h0, 1'b1, 32'h0);
    acc(WIN_BASE + 32'h4, 1'b0, 32'h0, 1'b1, 32'h0);
    acc(ENG + ENG_XCVR_OFS, 1'b0, 32'h0, 1'b1, 32'h3);
    acc(ENG + ENG_HSIC_OFS, 1'b0, 32'h0, 1'b1, 32'h3);
    chk(hs_current_source_on_o, 32'h1);
  endtask : t_reset
  task automatic t_drv;
    for (int i = 0; i < 4; i++) begin
      acc(WIN_BASE, 1'b1, 32'h1c8 | (i << 4) | i, 1'b1, 32'h0);
      chk(hs_tx_bit_pair_o, i);
      chk(hs_output_current_sel_o, i);
    end
    chk(line_swap_o, 32'h1);
    chk(hs_termination_on_o, 32'h1);
    acc(WIN_BASE, 1'b0, 32'h0, 1'b1, 32'h1fb);
    // Illegal mask code must not land, while the other fields do
    acc(WIN_BASE, 1'b1, 32'h084, 1'b1, 32'h0);
    chk(hs_tx_bit_valid_mask_o, 32'h3);
    chk(line_swap_o, 32'h0);
    chk(hs_termination_on_o, 32'h0);
  endtask : t_drv
  task automatic t_test;
    for (int i = 0; i < 4; i++) begin
      acc(WIN_BASE + 32'h4, 1'b1, (i << 5) | (i << 2) | i | ((i & 1) << 4), 1'b1, 32'h0);
      chk(reference_level_sel_o, i);
      chk(reference_to_test_pin_o, i == 3);
      chk(hs_edge_rate_sel_o, i);
      chk(ls_edge_rate_sel_o, i);
      chk(receiver_bias_boost_o, i & 1);
    end
    acc(WIN_BASE + 32'h4, 1'b1, 32'h80, 1'b1, 32'h0);
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk(detector_enable_o, 32'h0);
    tx_req <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1;
    chk(detector_enable_o, 32'h1);
    tx_req <= 1'b0;
  endtask : t_test
  task automatic t_eng;
    for (int i = 0; i < 4; i++) begin
      acc(ENG + ENG_XCVR_OFS, 1'b1, i << 4, 1'b1, 32'h0);
      chk(drive_boost_sel_o, i);
    end
    chk(line_swap_o, 32'h0);
    acc(ENG + ENG_XCVR_OFS, 1'b1, 32'hff, 1'b1, 32'h0);
    acc(ENG + ENG_XCVR_OFS, 1'b0, 32'h0, 1'b1, 32'h3f);
    chk(squelch_sel_o, 32'h7);
    chk(line_swap_o, 32'h1);
    acc(ENG + ENG_HSIC_OFS, 1'b1, 32'hff, 1'b1, 32'h0);
    acc(ENG + ENG_HSIC_OFS, 1'b0, 32'h0, 1'b1, 32'h1f);
    chk(hsic_resistor_trim_o, 32'h1f);
  endtask : t_eng
  task automatic t_decode;
    acc(WIN_BASE - 32'h4, 1'b0, 32'h0, 1'b0, 32'h0);
    acc(WIN_LAST + 32'h1, 1'b0, 32'h0, 1'b0, 32'h0);
    acc(WIN_LAST - 32'h3, 1'b1, 32'hffff_ffff, 1'b1, 32'h0);
    acc(WIN_LAST - 32'h3, 1'b0, 32'h0, 1'b1, 32'h0);
    acc(WIN_BASE + 32'h200, 1'b1, 32'h1ff, 1'b1, 32'h0);
    acc(WIN_BASE + 32'h200, 1'b0, 32'h0, 1'b1, 32'h0);
    acc(WIN_BASE + 32'h1, 1'b1, 32'h0, 1'b1, 32'h0);
    acc(WIN_BASE, 1'b0, 32'h0, 1'b1, 32'h0c4);
  endtask : t_decode
  task automatic t_select;
    acc(WIN_BASE, 1'b1, 32'hc0, 1'b1, 32'h0);
    chk(hs_current_source_on_o, 32'h1);
    acc(WIN_BASE + 32'h8, 1'b1, 32'h4, 1'b1, 32'h0);
    chk(transceiver_select_o, XCVR_FS);
    chk(hs_current_source_on_o, 32'h0);
    // Select change while the link is busy is dropped
    busy_req <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    acc(WIN_BASE + 32'h8, 1'b1, 32'hc, 1'b1, 32'h0);
    chk(transceiver_select_o, XCVR_FS);
    busy_req <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    acc(WIN_BASE + 32'h8, 1'b1, 32'hc, 1'b1, 32'h0);
    chk(transceiver_select_o, XCVR_LS_FS_EDGE);
    acc(WIN_BASE + 32'h8, 1'b0, 32'h0, 1'b1, 32'hc);
  endtask : t_select
  task automatic stop_test;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // Main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_drv();
    t_test();
    t_eng();
    t_decode();
    t_select();
    stop_test();
  end
  // Watchdog, far beyond the roughly 130 cycles the run needs
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule : usb_phy_tune_regs_bench
